// File: istc_consts.vh
// Constants for the image stamp and trigger counter block
`ifndef ISTC_CONSTS_VH
`define ISTC_CONSTS_VH

// Register byte offsets on the APB
`define ISTC_OFS_META_CTRL   12'h000
`define ISTC_OFS_COUNT_CTRL  12'h004
`define ISTC_OFS_COUNT_CMD   12'h008
`define ISTC_OFS_STAMP_NOW   12'h00C
`define ISTC_OFS_COUNT_NOW   12'h010
`define ISTC_OFS_STAMP_IMG   12'h014
`define ISTC_OFS_COUNT_IMG   12'h018
`define ISTC_OFS_STATUS      12'h01C

// Metadata control fields
`define ISTC_BIT_GLOBAL_ON   0
`define ISTC_BIT_KIND_SEL    4
`define ISTC_BIT_STAMP_ON    8
`define ISTC_BIT_TRIG_ON     9
`define ISTC_KIND_STAMP      1'b0
`define ISTC_KIND_TRIG       1'b1

// Counter control fields
`define ISTC_BIT_SLOT_LO     0
`define ISTC_BIT_SLOT_HI     1
`define ISTC_BIT_CAUSE_LO    4
`define ISTC_BIT_CAUSE_HI    5
`define ISTC_BIT_CLR_LO      8
`define ISTC_BIT_CLR_HI      9
`define ISTC_BIT_FREE_RUN    12
`define ISTC_SLOT_ONE        2'h1
`define ISTC_CAUSE_ACQ_TRIG  2'h1
`define ISTC_CLR_OFF         2'h0
`define ISTC_CLR_PIN_ONE     2'h1
`define ISTC_CLR_PIN_TWO     2'h2
`define ISTC_CLR_SOFTWARE    2'h3

// Counter reset value and first count value
`define ISTC_RST_COUNT       32'h0000_0000
`define ISTC_COUNT_FIRST     32'h0000_0001

// Time stamp field layout and wrap points
`define ISTC_SEC_LSB         0
`define ISTC_CYC_LSB         7
`define ISTC_OFF_LSB         20
`define ISTC_SEC_MAX         7'h7F
`define ISTC_CYC_MAX         13'h1F3F
`define ISTC_OFF_MAX         12'hBFF

// Offset tick phase accumulator: 24.576 MHz from 125 MHz = 3072/15625
`define ISTC_ACC_INC         14'h0C00
`define ISTC_ACC_MOD         14'h3D09
`endif

// File: istc_cycle_timer.v
// Bus cycle timer producing the 32-bit time stamp value
`timescale 1ns/1ns
`include "istc_consts.vh"
module istc_cycle_timer (
  input  wire        i_mclk,
  input  wire        i_sys_rst,
  output wire [31:0] o_stamp
);
  reg  [13:0] acc_q;
  reg  [11:0] off_q;
  reg  [12:0] cyc_q;
  reg  [6:0]  sec_q;
  wire [14:0] acc_sum = {1'b0, acc_q} + {1'b0, `ISTC_ACC_INC};
  wire        tick    = (acc_sum >= {1'b0, `ISTC_ACC_MOD});
  wire        off_wrap = tick && (off_q == `ISTC_OFF_MAX);
  wire        cyc_wrap = off_wrap && (cyc_q == `ISTC_CYC_MAX);

  // Fractional divider gives an average 24.576 MHz tick; jitter is one mclk
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      acc_q <= 14'h0000;
      off_q <= 12'h000;
      cyc_q <= 13'h0000;
      sec_q <= 7'h00;                                      // see R5
    end else begin
      acc_q <= tick ? acc_sum[13:0] - `ISTC_ACC_MOD : acc_sum[13:0];
      if (tick)
        off_q <= off_wrap ? 12'h000 : off_q + 12'h001;     // see R4
      if (off_wrap)
        cyc_q <= cyc_wrap ? 13'h0000 : cyc_q + 13'h0001;   // see R3
      if (cyc_wrap)
        sec_q <= sec_q + 7'h01;                            // see R2
    end
  end

  assign o_stamp = {off_q, cyc_q, sec_q};
endmodule

// File: istc_top.v
// Image time stamp and trigger counter with APB registers
//
// Overview of operation
// R1: Capture 32-bit stamp at acquisition trigger
// R2: Bits 0-6 seconds, wrap after 127
// R3: Bits 7-19 bus cycles, wrap 7999, carry
// R4: Bits 20-31 count 24.576 MHz, wrap 3071
// R5: Stamp counters restart from zero at reset
// R6: Global flag gates every metadata kind
// R7: Select kind, enable, then append each image
// R8: Append trigger count value with its image
// R9: Trigger counter starts at 1, increments
// R10: Counter wraps to 0 after maximum
// R11: Count every trigger, framed or not
// R12: No trigger count in free-run mode
// R13: Counter clears to 0 on power loss
// R14: Host picks slot one, trigger source first
// R15: Clear cause: pin one, two, software, off
// R16: Clear cause defaults to off
// R17: Software clear command clears counter
// R18: Pin clear synchronised, acts on rising edge
`timescale 1ns/1ns
`include "istc_consts.vh"
module istc_top (
  input  wire        i_mclk,
  input  wire        i_sys_rst,
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [11:0] i_paddr,
  input  wire [31:0] i_pwdata,
  output wire        o_pready,
  output wire        o_pslverr,
  output reg  [31:0] o_prdata,
  input  wire        i_acq_trigger,
  input  wire        i_frame_made,
  input  wire        i_input_pin_one,
  input  wire        i_input_pin_two,
  output reg         o_meta_valid,
  output reg         o_stamp_present,
  output reg         o_count_present,
  output reg  [31:0] o_stamp_value_field,
  output reg  [31:0] o_trig_count_field
);
  // Control registers
  reg         metadata_global_on_q;
  reg         metadata_kind_select_q;
  reg  [1:0]  metadata_kind_on_q;
  reg  [1:0]  count_slot_select_q;
  reg  [1:0]  count_increment_cause_q;
  reg  [1:0]  count_clear_cause_q;
  reg         free_run_q;
  reg  [31:0] count_q;
  reg  [31:0] count_d;
  reg         pin1_s1_q;
  reg         pin1_s2_q;
  reg         pin1_s3_q;
  reg         pin2_s1_q;
  reg         pin2_s2_q;
  reg         pin2_s3_q;
  reg         frame_q;
  wire [31:0] stamp_now;
  wire        wr_en;
  wire        rd_en;
  wire        sw_clear;
  wire        pin_clear;
  wire        count_armed;
  wire        trig_counts;
  wire        stamp_en;
  wire        trig_en;
  reg         addr_ok;

  istc_cycle_timer u_timer (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .o_stamp   (stamp_now)
  );

  // APB: zero wait state, every access completes in its access cycle
  assign o_pready  = 1'b1;
  assign wr_en     = i_psel & i_penable & i_pwrite;
  assign rd_en     = i_psel & ~i_pwrite;
  assign o_pslverr = i_psel & i_penable & ~addr_ok;

  // Address decode; unmapped offsets answer with an error
  always @* begin
    case (i_paddr)
      `ISTC_OFS_META_CTRL,
      `ISTC_OFS_COUNT_CTRL,
      `ISTC_OFS_COUNT_CMD,
      `ISTC_OFS_STAMP_NOW,
      `ISTC_OFS_COUNT_NOW,
      `ISTC_OFS_STAMP_IMG,
      `ISTC_OFS_COUNT_IMG,
      `ISTC_OFS_STATUS: addr_ok = 1'b1;
      default:          addr_ok = 1'b0;
    endcase
  end

  // Control register writes
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      metadata_global_on_q    <= 1'b0;
      metadata_kind_select_q  <= `ISTC_KIND_STAMP;
      metadata_kind_on_q      <= 2'b00;
      count_slot_select_q     <= `ISTC_SLOT_ONE;
      count_increment_cause_q <= `ISTC_CAUSE_ACQ_TRIG;
      count_clear_cause_q     <= `ISTC_CLR_OFF;                    // see R16
      free_run_q              <= 1'b0;
    end else if (wr_en && i_paddr == `ISTC_OFS_META_CTRL) begin
      metadata_global_on_q   <= i_pwdata[`ISTC_BIT_GLOBAL_ON];
      metadata_kind_select_q <= i_pwdata[`ISTC_BIT_KIND_SEL];
      if (!i_pwdata[`ISTC_BIT_GLOBAL_ON])
        metadata_kind_on_q <= 2'b00;                               // see R6
      else begin
        // Per-kind enable only accepted while global flag already set
        if (metadata_global_on_q) begin                            // see R6
          metadata_kind_on_q[0] <= i_pwdata[`ISTC_BIT_STAMP_ON];   // see R7
          metadata_kind_on_q[1] <= i_pwdata[`ISTC_BIT_TRIG_ON];    // see R7
        end
      end
    end else if (wr_en && i_paddr == `ISTC_OFS_COUNT_CTRL) begin
      count_slot_select_q     <= i_pwdata[`ISTC_BIT_SLOT_HI:`ISTC_BIT_SLOT_LO];
      count_increment_cause_q <= i_pwdata[`ISTC_BIT_CAUSE_HI:`ISTC_BIT_CAUSE_LO];
      free_run_q              <= i_pwdata[`ISTC_BIT_FREE_RUN];
      // Clear cause is only taken for slot one on the trigger event
      if (i_pwdata[`ISTC_BIT_SLOT_HI:`ISTC_BIT_SLOT_LO] == `ISTC_SLOT_ONE &&
          i_pwdata[`ISTC_BIT_CAUSE_HI:`ISTC_BIT_CAUSE_LO] == `ISTC_CAUSE_ACQ_TRIG)
        count_clear_cause_q <= i_pwdata[`ISTC_BIT_CLR_HI:`ISTC_BIT_CLR_LO]; // see R14, R15
    end
  end

  // Two-flop synchronisers; third flop only feeds edge detection
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pin1_s1_q <= 1'b0;
      pin1_s2_q <= 1'b0;
      pin1_s3_q <= 1'b0;
      pin2_s1_q <= 1'b0;
      pin2_s2_q <= 1'b0;
      pin2_s3_q <= 1'b0;
    end else begin
      pin1_s1_q <= i_input_pin_one;
      pin1_s2_q <= pin1_s1_q;
      pin1_s3_q <= pin1_s2_q;
      pin2_s1_q <= i_input_pin_two;
      pin2_s2_q <= pin2_s1_q;
      pin2_s3_q <= pin2_s2_q;
    end
  end

  // Clear requests from the chosen source
  assign pin_clear = (count_clear_cause_q == `ISTC_CLR_PIN_ONE && pin1_s2_q && !pin1_s3_q) ||
                     (count_clear_cause_q == `ISTC_CLR_PIN_TWO && pin2_s2_q && !pin2_s3_q); // see R18
  assign sw_clear  = wr_en && i_paddr == `ISTC_OFS_COUNT_CMD && i_pwdata[0] &&
                     count_clear_cause_q == `ISTC_CLR_SOFTWARE;                       // see R17
  assign count_armed = (count_slot_select_q == `ISTC_SLOT_ONE) &&
                       (count_increment_cause_q == `ISTC_CAUSE_ACQ_TRIG);
  // Free run has no external trigger, so the counter holds
  assign trig_counts = i_acq_trigger && !free_run_q && count_armed;                   // see R12

  // Trigger counter next value; a trigger coinciding with a clear counts as 1
  always @* begin
    count_d = count_q;
    if (pin_clear || sw_clear)
      count_d = trig_counts ? `ISTC_COUNT_FIRST : `ISTC_RST_COUNT;                    // see R17, R18
    else if (trig_counts)
      count_d = count_q + 32'h0000_0001;                   // see R9, R10, R11
  end

  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst)
      count_q <= `ISTC_RST_COUNT;                          // see R13
    else
      count_q <= count_d;
  end

  assign stamp_en = metadata_global_on_q & metadata_kind_on_q[0];
  assign trig_en  = metadata_global_on_q & metadata_kind_on_q[1] & ~free_run_q;

  // Per-image metadata latched at the acquisition trigger
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_meta_valid        <= 1'b0;
      o_stamp_present     <= 1'b0;
      o_count_present     <= 1'b0;
      o_stamp_value_field <= 32'h0000_0000;
      o_trig_count_field  <= 32'h0000_0000;
      frame_q             <= 1'b0;
    end else begin
      o_meta_valid <= i_acq_trigger;
      frame_q      <= i_frame_made;
      if (i_acq_trigger) begin
        o_stamp_present     <= stamp_en;                   // see R1, R7
        o_count_present     <= trig_en;                    // see R8, R12
        o_stamp_value_field <= stamp_en ? stamp_now : 32'h0000_0000; // see R1
        o_trig_count_field  <= trig_en ? count_d : 32'h0000_0000;    // see R8
      end
    end
  end

  // Read mux, registered nothing: data is valid during the access cycle
  always @* begin
    o_prdata = 32'h0000_0000;
    if (rd_en) begin
      case (i_paddr)
        `ISTC_OFS_META_CTRL: begin
          o_prdata[`ISTC_BIT_GLOBAL_ON] = metadata_global_on_q;
          o_prdata[`ISTC_BIT_KIND_SEL]  = metadata_kind_select_q;
          o_prdata[`ISTC_BIT_STAMP_ON]  = metadata_kind_on_q[0];
          o_prdata[`ISTC_BIT_TRIG_ON]   = metadata_kind_on_q[1];
        end
        `ISTC_OFS_COUNT_CTRL: begin
          o_prdata[`ISTC_BIT_SLOT_HI:`ISTC_BIT_SLOT_LO]   = count_slot_select_q;
          o_prdata[`ISTC_BIT_CAUSE_HI:`ISTC_BIT_CAUSE_LO] = count_increment_cause_q;
          o_prdata[`ISTC_BIT_CLR_HI:`ISTC_BIT_CLR_LO]     = count_clear_cause_q;
          o_prdata[`ISTC_BIT_FREE_RUN]                    = free_run_q;
        end
        `ISTC_OFS_STAMP_NOW: o_prdata = stamp_now;
        `ISTC_OFS_COUNT_NOW: o_prdata = free_run_q ? 32'h0000_0000 : count_q;
        `ISTC_OFS_STAMP_IMG: o_prdata = o_stamp_value_field;
        `ISTC_OFS_COUNT_IMG: o_prdata = o_trig_count_field;
        `ISTC_OFS_STATUS: begin
          o_prdata[0] = o_stamp_present;
          o_prdata[1] = o_count_present;
          o_prdata[2] = frame_q;
        end
        default: o_prdata = 32'h0000_0000;
      endcase
    end
  end
endmodule

// File: istc_top_assertions.sv
// Port checker for the image stamp and trigger counter
`timescale 1ns/1ns
module istc_top_assertions (
  input wire        i_mclk,
  input wire        i_sys_rst,
  input wire        i_psel,
  input wire        i_penable,
  input wire        i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire        o_pready,
  input wire        o_pslverr,
  input wire [31:0] o_prdata,
  input wire        i_acq_trigger,
  input wire        i_frame_made,
  input wire        i_input_pin_one,
  input wire        i_input_pin_two,
  input wire        o_meta_valid,
  input wire        o_stamp_present,
  input wire        o_count_present,
  input wire [31:0] o_stamp_value_field,
  input wire [31:0] o_trig_count_field
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  // Six quiet cycles leave no pin or software clear in flight
  sequence quiet_s;
    (!i_input_pin_one && !i_input_pin_two && !i_psel) [*6];
  endsequence
  sequence next_trig_s;
    o_meta_valid && o_count_present && i_acq_trigger;
  endsequence
  a_meta_follows: assert property (i_acq_trigger |=> o_meta_valid) else $error("meta late");
  a_meta_cause: assert property (o_meta_valid |-> $past(i_acq_trigger)) else $error("meta unasked");
  a_count_step: assert property (quiet_s ##0 next_trig_s |=>
    !o_count_present || o_trig_count_field == $past(o_trig_count_field) + 32'h0000_0001) else $error("count step");
  a_stamp_range: assert property (o_meta_valid && o_stamp_present |->
    o_stamp_value_field[31:20] <= 12'hBFF && o_stamp_value_field[19:7] <= 13'h1F3F) else $error("stamp range");
  a_count_absent: assert property (o_meta_valid && !o_count_present |-> o_trig_count_field == 32'h0000_0000)
    else $error("count not zero");
  a_stamp_absent: assert property (o_meta_valid && !o_stamp_present |-> o_stamp_value_field == 32'h0000_0000)
    else $error("stamp not zero");
  a_fields_hold: assert property (!i_acq_trigger |=> $stable(o_trig_count_field) && $stable(o_stamp_value_field))
    else $error("fields moved");
  a_bad_addr: assert property (i_psel && i_penable && i_paddr > 12'h01C |-> o_pslverr) else $error("no slverr");
  a_idle_read: assert property (!i_psel |-> o_prdata == 32'h0000_0000 && !o_pslverr) else $error("idle bus");
endmodule
bind istc_top istc_top_assertions i_chk (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .o_prdata(o_prdata), .i_acq_trigger(i_acq_trigger), .i_frame_made(i_frame_made),
  .i_input_pin_one(i_input_pin_one), .i_input_pin_two(i_input_pin_two), .o_meta_valid(o_meta_valid),
  .o_stamp_present(o_stamp_present), .o_count_present(o_count_present),
  .o_stamp_value_field(o_stamp_value_field), .o_trig_count_field(o_trig_count_field));

// File: istc_line_model.sv
// Model of the external trigger and clear input lines
`timescale 1ns/1ns
module istc_line_model (
  input  wire i_mclk,
  output reg  o_trig,
  output reg  o_pin_one,
  output reg  o_pin_two,
  output reg  o_frame
);
  // Lines idle low from time zero
  initial begin
    o_trig = 1'b0;
    o_pin_one = 1'b0;
    o_pin_two = 1'b0;
    o_frame = 1'b0;
  end
  // Back-to-back trigger pulses; random frame flag mimics overtriggering
  task burst(input int n);
    for (int k = 0; k < n; k++) begin
      @(posedge i_mclk);
      o_trig <= 1'b1;
      o_frame <= ($urandom_range(1, 0) != 0);
    end
    @(posedge i_mclk);
    o_trig <= 1'b0;
  endtask
  // Pulse held long enough for the synchroniser, then time to settle
  task pin(input int which);
    @(posedge i_mclk);
    if (which == 1) o_pin_one <= 1'b1;
    else o_pin_two <= 1'b1;
    repeat (4) @(posedge i_mclk);
    o_pin_one <= 1'b0;
    o_pin_two <= 1'b0;
    repeat (6) @(posedge i_mclk);
  endtask
endmodule

// File: test_image_stamp_trigger_counter.sv
// Self-checking bench of the stamp and trigger counter
`timescale 1ns/1ns
`include "istc_consts.vh"
module test_image_stamp_trigger_counter;
  reg         i_mclk = 1'b0, i_sys_rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  reg  [11:0] addr = 12'h000;
  reg  [31:0] wd = 32'h0000_0000;
  wire        trig, pin1, pin2, frame, rdy, serr, mval, spres, cpres;
  wire [31:0] prdata, sfield, cfield;
  logic [31:0] rd, exp_cnt;
  logic        err;
  int          num_errors = 0, comparisons = 0, cycles = 0;
  always #4 i_mclk = ~i_mclk;
  istc_line_model i_istc_line_model (.i_mclk(i_mclk), .o_trig(trig), .o_pin_one(pin1), .o_pin_two(pin2),
    .o_frame(frame));
  istc_top i_istc_top (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(addr), .i_pwdata(wd), .o_pready(rdy), .o_pslverr(serr), .o_prdata(prdata), .i_acq_trigger(trig),
    .i_frame_made(frame), .i_input_pin_one(pin1), .i_input_pin_two(pin2), .o_meta_valid(mval),
    .o_stamp_present(spres), .o_count_present(cpres), .o_stamp_value_field(sfield), .o_trig_count_field(cfield));
  // Hang guard sized well above the long stamp wait
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      conclude();
    end
  end
  task check(string what, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One APB transfer; waits for pready rather than assuming zero wait
  // Data is taken settled in the access cycle, then the request ends at the edge that sees pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_mclk);
    {psel, pen, pwr, addr, wd} <= {1'b1, 1'b0, w, a, d};
    @(posedge i_mclk);
    pen <= 1'b1;
    #1;
    while (rdy !== 1'b1 && n < 20) begin
      @(posedge i_mclk);
      #1;
      n++;
    end
    if (n == 20) num_errors++;
    rd = prdata;
    err = serr;
    @(posedge i_mclk);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // Next count after a clear action: restart only if that action is selected
  function logic [31:0] next_count(int cause, int action, logic [31:0] prev);
    return (cause == action) ? 32'h0000_0001 : prev + 32'h0000_0001;
  endfunction
  task conclude();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Main sequence
  initial begin
    void'($urandom(32'h0a87));
    repeat (2) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    apb(1'b0, `ISTC_OFS_COUNT_CTRL, 32'h0000_0000);
    check("count_ctrl", rd, 32'h0000_0011);
    $display("test reset done");
    apb(1'b1, `ISTC_OFS_META_CTRL, 32'h0000_0301);
    apb(1'b0, `ISTC_OFS_META_CTRL, 32'h0000_0000);
    check("meta_early", rd, 32'h0000_0001);
    apb(1'b1, `ISTC_OFS_META_CTRL, 32'h0000_0301);
    exp_cnt = $urandom_range(40, 1);
    i_istc_line_model.burst(exp_cnt);
    #1 check("count_field", cfield, exp_cnt);
    check("stamp_pres", {31'h0, spres}, 32'h0000_0001);
    apb(1'b1, `ISTC_OFS_META_CTRL, 32'h0000_0000);
    i_istc_line_model.burst(1);
    exp_cnt++;
    #1 check("count_off", {31'h0, cpres}, 32'h0000_0000);
    apb(1'b0, `ISTC_OFS_COUNT_NOW, 32'h0000_0000);
    check("count_live", rd, exp_cnt);
    $display("test gating done");
    apb(1'b1, `ISTC_OFS_META_CTRL, 32'h0000_0001);
    apb(1'b1, `ISTC_OFS_META_CTRL, 32'h0000_0201);
    apb(1'b1, `ISTC_OFS_COUNT_CTRL, 32'h0000_0300);
    apb(1'b0, `ISTC_OFS_COUNT_CTRL, 32'h0000_0000);
    check("slot_guard", rd, 32'h0000_0000);
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, `ISTC_OFS_COUNT_CTRL, 32'h0000_0011 | (c << 8));
      for (int a = 1; a < 4; a++) begin
        if (a == 3) apb(1'b1, `ISTC_OFS_COUNT_CMD, 32'h0000_0001);
        else i_istc_line_model.pin(a);
        exp_cnt = next_count(c, a, exp_cnt);
        i_istc_line_model.burst(1);
        #1 check("after_clear", cfield, exp_cnt);
      end
    end
    $display("test clear done");
    apb(1'b1, `ISTC_OFS_COUNT_CTRL, 32'h0000_1011);
    i_istc_line_model.burst(1);
    #1 check("free_pres", {31'h0, cpres}, 32'h0000_0000);
    apb(1'b0, `ISTC_OFS_COUNT_NOW, 32'h0000_0000);
    check("free_live", rd, 32'h0000_0000);
    apb(1'b0, `ISTC_OFS_STATUS, 32'h0000_0000);
    check("status", rd, {29'h0, frame, 2'b00});
    apb(1'b0, 12'h020, 32'h0000_0000);
    check("bad_err", {31'h0, err}, 32'h0000_0001);
    check("bad_data", rd, 32'h0000_0000);
    $display("test free run and decode done");
    @(posedge i_mclk);
    i_sys_rst <= 1'b1;
    @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    apb(1'b0, `ISTC_OFS_COUNT_NOW, 32'h0000_0000);
    check("count_rst", rd, 32'h0000_0000);
    apb(1'b0, `ISTC_OFS_STAMP_NOW, 32'h0000_0000);
    check("stamp_rst", {rd[19:0] == 20'h0_0000, rd[31:20] < 12'h004}, 2'h3);
    repeat (15700) @(posedge i_mclk);
    apb(1'b0, `ISTC_OFS_STAMP_NOW, 32'h0000_0000);
    check("cycle_carry", {19'h0, rd[19:7]}, 32'h0000_0001);
    check("offset_wrap", {rd[31:20] > 12'h00C, rd[31:20] < 12'h014}, 2'h3);
    $display("test stamp done");
    conclude();
  end
endmodule
